// ---- hdl/osw_regs.sv ----
// module: window-2 overlay and preamplifier register bank with window-2 placement logic
module osw_regs (
  input wire logic clk,
  input wire logic rstn,
  // register port from the serial control decoder
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_r,
  output logic reg_rvalid_r,
  // vertical timing
  input wire logic frame_start,
  input wire logic char_line_tick,
  output logic win2_top_r,
  output logic win2_active_r,
  // page RAM fetch
  output logic page_rd_r,
  output logic [osw_pkg::OSW_PADDR_W-1:0] page_addr_r,
  input wire logic [7:0] page_rdata,
  output logic row_start_valid_r,
  output logic [7:0] row_start_code_r,
  // horizontal pixel path
  input wire logic line_start,
  input wire logic char_valid,
  input wire logic [osw_pkg::OSW_FONT_W-1:0] char_font,
  input wire logic pix_tick,
  output logic char_ready_r,
  output logic pix_valid_r,
  output logic pix_out_r,
  output logic col_double_r,
  // preamplifier controls
  output logic [osw_pkg::OSW_GAIN_W-1:0] blue_channel_gain_r,
  output logic [osw_pkg::OSW_GAIN_W-1:0] green_channel_gain_r,
  output logic [osw_pkg::OSW_GAIN_W-1:0] red_channel_gain_r,
  output logic [osw_pkg::OSW_GAIN_W-1:0] common_contrast_gain_r,
  output logic [osw_pkg::OSW_CONV_W-1:0] first_converter_code_r,
  output logic [osw_pkg::OSW_CONV_W-1:0] second_converter_code_r,
  output logic [osw_pkg::OSW_CONV_W-1:0] third_converter_code_r
);
  import osw_pkg::*;

  logic [OSW_VSTART_W-1:0] window2_vertical_start_r;
  logic [OSW_PADDR_W-1:0] window2_page_start_address_r;
  logic [OSW_COLS-1:0] window2_column_double_width_r;
  logic [OSW_LINE_W-1:0] line_cnt_r;
  logic [OSW_LINE_W-1:0] top_line;
  logic [7:0] rdata_nxt;
  logic page_fetch_pend_r;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction

  // ==========================================================
  // write strobes, one per mapped byte address
  // writes to unmapped addresses match no strobe and are dropped
  logic wr_vstart;
  logic wr_pstart_lo;
  logic wr_pstart_hi;
  logic wr_colw_b0;
  logic wr_colw_b1;
  logic wr_colw_b2;
  logic wr_colw_b3;
  logic wr_blue;
  logic wr_green;
  logic wr_red;
  logic wr_contrast;
  logic wr_conv1;
  logic wr_conv2;
  logic wr_conv3;

  assign wr_vstart = reg_wr && hit(reg_addr, OSW_ADDR_VSTART);
  assign wr_pstart_lo = reg_wr && hit(reg_addr, OSW_ADDR_PSTART_LO);
  assign wr_pstart_hi = reg_wr && hit(reg_addr, OSW_ADDR_PSTART_HI);
  assign wr_colw_b0 = reg_wr && hit(reg_addr, OSW_ADDR_COLW_B0);
  assign wr_colw_b1 = reg_wr && hit(reg_addr, OSW_ADDR_COLW_B1);
  assign wr_colw_b2 = reg_wr && hit(reg_addr, OSW_ADDR_COLW_B2);
  assign wr_colw_b3 = reg_wr && hit(reg_addr, OSW_ADDR_COLW_B3);
  assign wr_blue = reg_wr && hit(reg_addr, OSW_ADDR_BLUE_GAIN);
  assign wr_green = reg_wr && hit(reg_addr, OSW_ADDR_GREEN_GAIN);
  assign wr_red = reg_wr && hit(reg_addr, OSW_ADDR_RED_GAIN);
  assign wr_contrast = reg_wr && hit(reg_addr, OSW_ADDR_CONTRAST);
  assign wr_conv1 = reg_wr && hit(reg_addr, OSW_ADDR_CONV1);
  assign wr_conv2 = reg_wr && hit(reg_addr, OSW_ADDR_CONV2);
  assign wr_conv3 = reg_wr && hit(reg_addr, OSW_ADDR_CONV3);

  // ==========================================================
  // overlay window registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window2_vertical_start_r <= OSW_RST_BYTE;
    end else if (wr_vstart) begin
      window2_vertical_start_r <= reg_wdata;
    end
  end

  // each address byte takes effect alone, no staging register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window2_page_start_address_r <= OSW_RST_PADDR;
    end else begin
      if (wr_pstart_lo) begin
        window2_page_start_address_r[7:0] <= reg_wdata;
      end
      if (wr_pstart_hi) begin
        window2_page_start_address_r[OSW_PADDR_W-1] <= reg_wdata[0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      window2_column_double_width_r <= OSW_RST_COLW;
    end else begin
      if (wr_colw_b0) begin
        window2_column_double_width_r[7:0] <= reg_wdata;
      end
      if (wr_colw_b1) begin
        window2_column_double_width_r[15:8] <= reg_wdata;
      end
      if (wr_colw_b2) begin
        window2_column_double_width_r[23:16] <= reg_wdata;
      end
      if (wr_colw_b3) begin
        window2_column_double_width_r[31:24] <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // preamplifier registers
  // bit 7 of the gain bytes is not stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blue_channel_gain_r <= OSW_RST_GAIN;
    end else if (wr_blue) begin
      blue_channel_gain_r <= reg_wdata[OSW_GAIN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      green_channel_gain_r <= OSW_RST_GAIN;
    end else if (wr_green) begin
      green_channel_gain_r <= reg_wdata[OSW_GAIN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      red_channel_gain_r <= OSW_RST_GAIN;
    end else if (wr_red) begin
      red_channel_gain_r <= reg_wdata[OSW_GAIN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      common_contrast_gain_r <= OSW_RST_GAIN;
    end else if (wr_contrast) begin
      common_contrast_gain_r <= reg_wdata[OSW_GAIN_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_converter_code_r <= OSW_RST_BYTE;
    end else if (wr_conv1) begin
      first_converter_code_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      second_converter_code_r <= OSW_RST_BYTE;
    end else if (wr_conv2) begin
      second_converter_code_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      third_converter_code_r <= OSW_RST_BYTE;
    end else if (wr_conv3) begin
      third_converter_code_r <= reg_wdata;
    end
  end

  // ==========================================================
  // read-back mux, unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      OSW_ADDR_VSTART: rdata_nxt = window2_vertical_start_r;
      OSW_ADDR_PSTART_LO: rdata_nxt = window2_page_start_address_r[7:0];
      OSW_ADDR_PSTART_HI: rdata_nxt = {7'h00, window2_page_start_address_r[OSW_PADDR_W-1]};
      OSW_ADDR_COLW_B0: rdata_nxt = window2_column_double_width_r[7:0];
      OSW_ADDR_COLW_B1: rdata_nxt = window2_column_double_width_r[15:8];
      OSW_ADDR_COLW_B2: rdata_nxt = window2_column_double_width_r[23:16];
      OSW_ADDR_COLW_B3: rdata_nxt = window2_column_double_width_r[31:24];
      OSW_ADDR_BLUE_GAIN: rdata_nxt = {1'b0, blue_channel_gain_r};
      OSW_ADDR_GREEN_GAIN: rdata_nxt = {1'b0, green_channel_gain_r};
      OSW_ADDR_RED_GAIN: rdata_nxt = {1'b0, red_channel_gain_r};
      OSW_ADDR_CONTRAST: rdata_nxt = {1'b0, common_contrast_gain_r};
      OSW_ADDR_CONV1: rdata_nxt = first_converter_code_r;
      OSW_ADDR_CONV2: rdata_nxt = second_converter_code_r;
      OSW_ADDR_CONV3: rdata_nxt = third_converter_code_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_r <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end else begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd) begin
        reg_rdata_r <= rdata_nxt;
      end
    end
  end

  // ==========================================================
  // vertical placement in character lines
  assign top_line = OSW_LINE_W'(window2_vertical_start_r * OSW_VSTART_MULT);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_cnt_r <= '0;
      win2_top_r <= 1'b0;
      win2_active_r <= 1'b0;
    end else begin
      win2_top_r <= 1'b0;
      if (frame_start) begin
        line_cnt_r <= '0;
        win2_active_r <= 1'b0;
      end else if (char_line_tick) begin
        // one tick per character pixel line, however many scan lines it spans
        if (line_cnt_r != '1) begin
          line_cnt_r <= line_cnt_r + 9'h001;
        end
        if (line_cnt_r == top_line) begin
          win2_top_r <= 1'b1;
          win2_active_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // first-row fetch from the page RAM, one-cycle read latency
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page_rd_r <= 1'b0;
      page_addr_r <= OSW_RST_PADDR;
      page_fetch_pend_r <= 1'b0;
      row_start_valid_r <= 1'b0;
      row_start_code_r <= 8'h00;
    end else begin
      page_rd_r <= win2_top_r;
      page_fetch_pend_r <= page_rd_r;
      row_start_valid_r <= page_fetch_pend_r;
      if (win2_top_r) begin
        page_addr_r <= window2_page_start_address_r;
      end
      if (page_fetch_pend_r) begin
        row_start_code_r <= page_rdata;
      end
    end
  end

  // ==========================================================
  // horizontal pixel expansion
  osw_col_expander u_expander (
    .clk(clk),
    .rstn(rstn),
    .line_start(line_start),
    .char_valid(char_valid),
    .char_font(char_font),
    .pix_tick(pix_tick),
    .double_en(window2_column_double_width_r),
    .char_ready_r(char_ready_r),
    .pix_valid_r(pix_valid_r),
    .pix_out_r(pix_out_r),
    .col_double_r(col_double_r)
  );
endmodule

// ---- shared/osw_pkg.sv ----
// package: register map, field layouts and constants of the window-2 and preamp register bank
package osw_pkg;
  // register byte addresses on the serial control register port
  localparam logic [15:0] OSW_ADDR_VSTART = 16'h8419;
  localparam logic [15:0] OSW_ADDR_PSTART_LO = 16'h841A;
  localparam logic [15:0] OSW_ADDR_PSTART_HI = 16'h841B;
  localparam logic [15:0] OSW_ADDR_COLW_B0 = 16'h841C;
  localparam logic [15:0] OSW_ADDR_COLW_B1 = 16'h841D;
  localparam logic [15:0] OSW_ADDR_COLW_B2 = 16'h841E;
  localparam logic [15:0] OSW_ADDR_COLW_B3 = 16'h841F;
  localparam logic [15:0] OSW_ADDR_BLUE_GAIN = 16'h8430;
  localparam logic [15:0] OSW_ADDR_GREEN_GAIN = 16'h8431;
  localparam logic [15:0] OSW_ADDR_RED_GAIN = 16'h8432;
  localparam logic [15:0] OSW_ADDR_CONTRAST = 16'h8433;
  localparam logic [15:0] OSW_ADDR_CONV1 = 16'h8434;
  localparam logic [15:0] OSW_ADDR_CONV2 = 16'h8435;
  localparam logic [15:0] OSW_ADDR_CONV3 = 16'h8436;

  // field widths
  localparam int OSW_VSTART_W = 8;
  localparam int OSW_PADDR_W = 9;
  localparam int OSW_GAIN_W = 7;
  localparam int OSW_CONV_W = 8;
  localparam int OSW_LINE_W = 9;
  localparam int OSW_COLS = 32;
  localparam int OSW_COL_IDX_W = 6;
  localparam int OSW_FONT_W = 12;
  localparam int OSW_BIT_IDX_W = 4;

  // vertical start is counted in units of two character lines
  localparam logic [OSW_LINE_W-1:0] OSW_VSTART_MULT = 9'h002;
  localparam logic [OSW_BIT_IDX_W-1:0] OSW_LAST_FONT_BIT = 4'hB;
  localparam logic [OSW_COL_IDX_W-1:0] OSW_COL_LIMIT = 6'h20;

  // reset values (none documented, cleared)
  localparam logic [7:0] OSW_RST_BYTE = 8'h00;
  localparam logic [OSW_PADDR_W-1:0] OSW_RST_PADDR = 9'h000;
  localparam logic [OSW_COLS-1:0] OSW_RST_COLW = 32'h0000_0000;
  localparam logic [OSW_GAIN_W-1:0] OSW_RST_GAIN = 7'h00;

  // pixel expander states, gray along idle -> first copy -> second copy
  typedef enum logic [1:0] {
    OSW_ST_IDLE = 2'b00,
    OSW_ST_FIRST = 2'b01,
    OSW_ST_SECOND = 2'b11
  } osw_pix_state_t;
endpackage

// ---- hdl/osw_col_expander.sv ----
// module: horizontal font pixel serialiser with per-column double width
module osw_col_expander (
  input wire logic clk,
  input wire logic rstn,
  input wire logic line_start,
  input wire logic char_valid,
  input wire logic [osw_pkg::OSW_FONT_W-1:0] char_font,
  input wire logic pix_tick,
  input wire logic [osw_pkg::OSW_COLS-1:0] double_en,
  output logic char_ready_r,
  output logic pix_valid_r,
  output logic pix_out_r,
  output logic col_double_r
);
  import osw_pkg::*;

  osw_pix_state_t state_r;
  logic [OSW_FONT_W-1:0] shift_r;
  logic [OSW_BIT_IDX_W-1:0] bit_idx_r;
  logic [OSW_COL_IDX_W-1:0] col_idx_r;

  // columns past the limit are always normal width
  function automatic logic col_is_double(input logic [OSW_COL_IDX_W-1:0] idx,
                                         input logic [OSW_COLS-1:0] en);
    col_is_double = (idx < OSW_COL_LIMIT) && en[idx[OSW_COL_IDX_W-2:0]];
  endfunction

  // ==========================================================
  // column counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      col_idx_r <= '0;
    end else if (line_start) begin
      col_idx_r <= '0;
    end else if (state_r == OSW_ST_IDLE && char_valid && col_idx_r < OSW_COL_LIMIT) begin
      col_idx_r <= col_idx_r + 6'h01;
    end
  end

  // ==========================================================
  // pixel sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= OSW_ST_IDLE;
      shift_r <= '0;
      bit_idx_r <= '0;
      char_ready_r <= 1'b1;
      pix_valid_r <= 1'b0;
      pix_out_r <= 1'b0;
      col_double_r <= 1'b0;
    end else begin
      pix_valid_r <= 1'b0;
      if (line_start) begin
        state_r <= OSW_ST_IDLE;
        char_ready_r <= 1'b1;
      end else begin
        unique case (state_r)
          OSW_ST_IDLE: begin
            if (char_valid) begin
              shift_r <= char_font;
              bit_idx_r <= '0;
              col_double_r <= col_is_double(col_idx_r, double_en);
              char_ready_r <= 1'b0;
              state_r <= OSW_ST_FIRST;
            end
          end
          OSW_ST_FIRST: begin
            if (pix_tick) begin
              pix_valid_r <= 1'b1;
              pix_out_r <= shift_r[OSW_FONT_W-1];
              if (col_double_r) begin
                state_r <= OSW_ST_SECOND;
              end else if (bit_idx_r == OSW_LAST_FONT_BIT) begin
                state_r <= OSW_ST_IDLE;
                char_ready_r <= 1'b1;
              end else begin
                shift_r <= {shift_r[OSW_FONT_W-2:0], 1'b0};
                bit_idx_r <= bit_idx_r + 4'h1;
              end
            end
          end
          OSW_ST_SECOND: begin
            if (pix_tick) begin
              pix_valid_r <= 1'b1;
              pix_out_r <= shift_r[OSW_FONT_W-1];
              if (bit_idx_r == OSW_LAST_FONT_BIT) begin
                state_r <= OSW_ST_IDLE;
                char_ready_r <= 1'b1;
              end else begin
                shift_r <= {shift_r[OSW_FONT_W-2:0], 1'b0};
                bit_idx_r <= bit_idx_r + 4'h1;
                state_r <= OSW_ST_FIRST;
              end
            end
          end
          default: begin
            state_r <= OSW_ST_IDLE;
            char_ready_r <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// ---- testbench/osw_regs_properties.sv ----
// checker: port-level properties of the window-2 and preamp register bank
module osw_regs_chk
  import osw_pkg::*;
(
  input logic clk,
  input logic rstn,
  input logic [15:0] reg_addr,
  input logic reg_wr,
  input logic reg_rd,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata_r,
  input logic reg_rvalid_r,
  input logic frame_start,
  input logic char_line_tick,
  input logic win2_top_r,
  input logic win2_active_r,
  input logic page_rd_r,
  input logic row_start_valid_r,
  input logic line_start,
  input logic char_valid,
  input logic char_ready_r,
  input logic pix_tick,
  input logic pix_valid_r,
  input logic [osw_pkg::OSW_GAIN_W-1:0] blue_channel_gain_r
);
  // ==========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_fetch; ##1 page_rd_r ##2 row_start_valid_r; endsequence
  property p_fetch; win2_top_r |-> s_fetch; endproperty
  a_fetch: assert property (p_fetch) else $error("row start fetch out of step");
  property p_top; win2_top_r |-> $past(char_line_tick) && !$past(frame_start) && win2_active_r; endproperty
  a_top: assert property (p_top) else $error("top without a line tick");
  property p_act; win2_active_r && !frame_start |=> win2_active_r; endproperty
  a_act: assert property (p_act) else $error("window dropped mid frame");
  property p_clear; frame_start |=> !win2_active_r; endproperty
  a_clear: assert property (p_clear) else $error("frame start did not clear");
  property p_rd; reg_rd |=> reg_rvalid_r; endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
  property p_rv; reg_rvalid_r |-> $past(reg_rd); endproperty
  a_rv: assert property (p_rv) else $error("read answer without read");
  property p_blue; reg_wr && reg_addr == OSW_ADDR_BLUE_GAIN |=> blue_channel_gain_r == 7'($past(reg_wdata)); endproperty
  a_blue: assert property (p_blue) else $error("blue gain not written");
  property p_hold; !(reg_wr && reg_addr == OSW_ADDR_BLUE_GAIN) |=> $stable(blue_channel_gain_r); endproperty
  a_hold: assert property (p_hold) else $error("blue gain changed unwritten");
  property p_unm; reg_rd && reg_addr[15:4] == 12'h842 |=> reg_rdata_r == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read not zero");
  property p_take; char_valid && char_ready_r && !line_start |=> !char_ready_r; endproperty
  a_take: assert property (p_take) else $error("char not taken");
  property p_pix; pix_valid_r |-> $past(pix_tick); endproperty
  a_pix: assert property (p_pix) else $error("pixel without tick");
endmodule
bind osw_regs osw_regs_chk u_chk (.*);

// ---- testbench/osw_host.sv ----
// host model: byte writes and reads on the register port
module osw_host (
  input logic clk,
  output logic [15:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata_r,
  input logic reg_rvalid_r
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    {reg_wr, reg_rd} = 2'b00;
  end
  // one request per call, released address and data lines show inverted values, wr and rd return low
  task automatic req(input logic [15:0] a, input logic [7:0] d, input logic w);
    @(posedge clk);
    #5;
    reg_addr = a;
    reg_wdata = d;
    {reg_wr, reg_rd} = {w, !w};
    @(posedge clk);
    #5;
    {reg_wr, reg_rd} = 2'b00;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    req(a, d, 1'b1);
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
    req(a, 8'h00, 1'b0);
    d = reg_rdata_r;
    v = reg_rvalid_r;
  endtask
endmodule

// ---- testbench/osw_regs_bench.sv ----
// testbench: register bank against a behavioural mirror
module osw_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import osw_pkg::*;
  logic clk = 1'b0;
  logic rstn, reg_wr, reg_rd, frame_start, char_line_tick, line_start, char_valid, pix_tick, rd_q;
  logic reg_rvalid_r, win2_top_r, win2_active_r, page_rd_r, row_start_valid_r;
  logic char_ready_r, pix_valid_r, pix_out_r, col_double_r, ok;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata_r, page_rdata, row_start_code_r, rb;
  logic [OSW_PADDR_W-1:0] page_addr_r;
  logic [OSW_FONT_W-1:0] char_font;
  logic [OSW_GAIN_W-1:0] blue_channel_gain_r, green_channel_gain_r, red_channel_gain_r, common_contrast_gain_r;
  logic [OSW_CONV_W-1:0] first_converter_code_r, second_converter_code_r, third_converter_code_r;
  logic [7:0] mdl [int];
  logic [31:0] en;
  int fails = 0;
  int total_checks = 0;
  int seed = 12;
  int d;
  osw_regs uut (.*);
  osw_host host (.*);
  // ==========================================
  // clock and page memory, data valid only the cycle after a read
  always #25 clk = ~clk;
  always @(posedge clk) rd_q <= page_rd_r;
  assign page_rdata = rd_q ? page_addr_r[7:0] ^ 8'h5A : ~(page_addr_r[7:0] ^ 8'h5A);
  // ==========================================
  // helpers
  task automatic cyc;
    @(posedge clk);
    #5;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic int mk(int a);
    if (a == 16'h841B) return 1;
    if ((a >= 16'h8419 && a <= 16'h841F) || (a >= 16'h8434 && a <= 16'h8436)) return 8'hFF;
    if (a >= 16'h8430 && a <= 16'h8433) return 8'h7F;
    return 0;
  endfunction
  task automatic vfr(input int v);
    int n;
    int got;
    n = 0;
    got = 0;
    host.wr(OSW_ADDR_VSTART, 8'(v));
    frame_start = 1'b1;
    cyc;
    frame_start = 1'b0;
    for (int i = 0; i < 400 && got == 0; i++) begin
      char_line_tick = (i % 2 == 0);
      n += int'(char_line_tick);
      cyc;
      got = int'(win2_top_r === 1'b1);
    end
    char_line_tick = 1'b0;
    if (got == 0) begin
      fails++;
      complete_run;
    end
    chk("top line", n - 1, 2 * v);
    chk("active", win2_active_r, 1);
    for (int i = 0; i < 8 && row_start_valid_r !== 1'b1; i++) cyc;
    chk("row valid", row_start_valid_r, 1);
    chk("page addr", page_addr_r, {mdl[16'h841B][0], mdl[16'h841A]});
    chk("row code", row_start_code_r, mdl[16'h841A] ^ 8'h5A);
  endtask
  task automatic char1(input int c);
    logic [11:0] f;
    int dbl;
    logic q [$];
    f = 12'($random(seed));
    dbl = (c < 32) ? int'(en[c]) : 0;
    for (int b = 11; b >= 0; b--) begin
      q.push_back(f[b]);
      if (dbl != 0) q.push_back(f[b]);
    end
    char_valid = 1'b1;
    char_font = f;
    cyc;
    char_valid = 1'b0;
    chk("double", col_double_r, dbl);
    pix_tick = 1'b1;
    for (int i = 0; i < 60 && char_ready_r !== 1'b1; i++) begin
      cyc;
      if (pix_valid_r === 1'b1) chk("pixel", pix_out_r, q.size() > 0 ? q.pop_front() : 1'bx);
    end
    pix_tick = 1'b0;
    chk("pixel count", q.size(), 0);
    if (char_ready_r !== 1'b1) begin
      fails++;
      complete_run;
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    rstn = 1'b0;
    {frame_start, char_line_tick, line_start, char_valid, pix_tick} = 5'h00;
    char_font = 12'h000;
    repeat (12) @(posedge clk);
    #5;
    rstn = 1'b1;
    for (int a = 16'h8418; a < 16'h8438; a++) begin
      d = $random(seed);
      if (mk(a) != 0) d = d & mk(a);
      mdl[a] = 8'(d & mk(a));
      host.wr(16'(a), 8'(d));
    end
    host.wr(OSW_ADDR_BLUE_GAIN, 8'hFF);
    mdl[16'h8430] = 8'h7F;
    for (int a = 16'h8418; a < 16'h8438; a++) begin
      host.rd(16'(a), rb, ok);
      chk("read valid", ok, 1);
      chk("readback", rb, mdl[a]);
    end
    chk("blue gain", blue_channel_gain_r, mdl[16'h8430]);
    chk("green gain", green_channel_gain_r, mdl[16'h8431]);
    chk("red gain", red_channel_gain_r, mdl[16'h8432]);
    chk("contrast", common_contrast_gain_r, mdl[16'h8433]);
    chk("code 1", first_converter_code_r, mdl[16'h8434]);
    chk("code 2", second_converter_code_r, mdl[16'h8435]);
    chk("code 3", third_converter_code_r, mdl[16'h8436]);
    vfr(0);
    vfr(1 + ($random(seed) & 15));
    en = {mdl[16'h841F], mdl[16'h841E], mdl[16'h841D], mdl[16'h841C]};
    line_start = 1'b1;
    cyc;
    line_start = 1'b0;
    for (int c = 0; c < 34; c++) char1(c);
    complete_run;
  end
endmodule
